// >>> include/scr_pkg.sv
// package for the serial cable clock and pin routing block
package scr_pkg;
    // register byte offsets on the plain register port
    localparam logic [3:0] PIN_CTRL_OFS = 4'h0; // pin control register
    localparam logic [3:0] PIN_STAT_OFS = 4'h4; // pin status register

    // clock source codes shared by the transmit clock and both controller pins
    typedef enum logic [2:0] {
        SRC_PLL = 3'h0, // channel pll clock
        SRC_PLL_INV = 3'h1, // inverted channel pll clock
        SRC_RXC = 3'h2, // cable receive clock
        SRC_AUX = 3'h3, // auxiliary clock taken as input
        SRC_CTL_B = 3'h4, // controller clock pin b
        SRC_CTL_A = 3'h5, // controller clock pin a
        SRC_HIGH = 3'h6, // constant high
        SRC_LOW = 3'h7 // constant low
    } scr_src_t;

    // pin control register layout, msb first
    typedef struct packed {
        logic dce; // d31: 1 = dce, 0 = dte
        logic [7:0] rsv; // d30:23 reserved, read as zero
        logic [1:0] rts_gp; // d22:21 [1] force rts level, [0] level
        logic [1:0] txd_gp; // d20:19 [1] force txd level, [0] level
        logic [1:0] aux; // d18:17 [1] output, [0] level
        logic [1:0] dcd; // d16:15 [1] output, [0] level
        logic int_lb; // d14 internal loopback
        logic ext_lb; // d13 external loopback
        logic xcvr_en; // d12 cable transceiver enable
        logic rs232; // d11 protocol: 1 = rs-232, 0 = rs-422/485
        logic b_drive; // d10 drive controller clock pin b
        logic a_drive; // d9 drive controller clock pin a
        scr_src_t txc_src; // d8:6 cable transmit clock source
        scr_src_t b_src; // d5:3 controller clock pin b source
        scr_src_t a_src; // d2:0 controller clock pin a source
    } scr_ctrl_t;

    // reset value: pin b and cable tx clock from pll, pin a from rx clock
    localparam scr_ctrl_t PIN_CTRL_RST = '{
        dce: 1'b0, rsv: 8'h00, rts_gp: 2'h0, txd_gp: 2'h0, aux: 2'h0,
        dcd: 2'h0, int_lb: 1'b0, ext_lb: 1'b0, xcvr_en: 1'b0,
        rs232: 1'b0, b_drive: 1'b1, a_drive: 1'b1, txc_src: SRC_PLL,
        b_src: SRC_PLL, a_src: SRC_RXC};

    // one transceiver pin as two signals
    typedef struct packed {
        logic o; // level driven
        logic oe; // high while driven
    } scr_drv_t;

    // pin status bit positions
    localparam int ST_CLK1 = 0;
    localparam int ST_CLK2 = 1;
    localparam int ST_DAT1 = 2;
    localparam int ST_DAT2 = 3;
    localparam int ST_HS1 = 4;
    localparam int ST_HS2 = 5;
    localparam int ST_DCD = 6;
    localparam int ST_AUX = 7;
    localparam int ST_W = 8;
endpackage

// >>> verilog/scr_pin_route.sv
// per-channel clock source selection and cable pin routing
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module scr_pin_route #(
    parameter int ADDR_W = 4 // register port address width
) (
    input wire logic clk_sys, // 50 mhz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic channel_pll_clock, // this channel's pll clock
    input wire logic ctl_clk_a_i, // controller clock pin a level
    output logic ctl_clk_a_o, // controller clock pin a drive
    output logic ctl_clk_a_oe, // high while pin a is driven
    input wire logic ctl_clk_b_i, // controller clock pin b level
    output logic ctl_clk_b_o, // controller clock pin b drive
    output logic ctl_clk_b_oe, // high while pin b is driven
    input wire logic ctl_txd, // transmit data from controller
    input wire logic ctl_rts, // rts from controller
    output logic ctl_rxd, // receive data to controller
    output logic ctl_cts, // cts to controller
    output logic ctl_dcd, // dcd to controller
    output logic rs232_mode, // transceiver protocol select
    input wire logic clk_pin1_i, // cable clock pin pair, dte tx side
    output logic clk_pin1_o, // drive level
    output logic clk_pin1_oe, // high while driven
    input wire logic clk_pin2_i, // cable clock pin pair, dte rx side
    output logic clk_pin2_o, // drive level
    output logic clk_pin2_oe, // high while driven
    input wire logic dat_pin1_i, // cable data pin, dte tx side
    output logic dat_pin1_o, // drive level
    output logic dat_pin1_oe, // high while driven
    input wire logic dat_pin2_i, // cable data pin, dte rx side
    output logic dat_pin2_o, // drive level
    output logic dat_pin2_oe, // high while driven
    input wire logic hs_pin1_i, // cable handshake pin, dte rts side
    output logic hs_pin1_o, // drive level
    output logic hs_pin1_oe, // high while driven
    input wire logic hs_pin2_i, // cable handshake pin, dte cts side
    output logic hs_pin2_o, // drive level
    output logic hs_pin2_oe, // high while driven
    input wire logic dcd_pin_i, // cable dcd level
    output logic dcd_pin_o, // dcd drive level
    output logic dcd_pin_oe, // high while dcd driven
    input wire logic aux_pin_i, // cable auxiliary clock level
    output logic aux_pin_o, // auxiliary clock drive level
    output logic aux_pin_oe // high while auxiliary clock driven
);

    // the offsets need at least three address bits
    if (ADDR_W < 3) begin : g_chk
        $error("scr_pin_route: ADDR_W must be at least 3");
    end

    scr_pkg::scr_ctrl_t ctrl; // pin control register
    scr_pkg::scr_ctrl_t next_ctrl; // its next value
    logic [scr_pkg::ST_W-1:0] stat; // sampled cable levels
    logic [scr_pkg::ST_W-1:0] next_stat; // next sample
    logic [31:0] next_rdata; // next read data
    logic rxd_q, cts_q, dcd_q; // registered receive side
    logic next_rxd, next_cts, next_dcd; // their next values
    logic txd_q, rts_q; // registered transmit side
    logic next_txd, next_rts; // their next values
    logic rx_clk; // receive clock seen by the routing
    logic tx_clk; // selected cable transmit clock
    logic tx_at2; // transmit side sits on pin 2 (dce)

    // one mux serves all three clock destinations
    function automatic logic pick_src(input scr_pkg::scr_src_t s,
        input logic pll, input logic cable_receive_clock, input logic aux,
        input logic cb, input logic ca);
        case (s)
            scr_pkg::SRC_PLL: pick_src = pll;
            scr_pkg::SRC_PLL_INV: pick_src = ~pll;
            scr_pkg::SRC_RXC: pick_src = cable_receive_clock;
            scr_pkg::SRC_AUX: pick_src = aux;
            scr_pkg::SRC_CTL_B: pick_src = cb;
            scr_pkg::SRC_CTL_A: pick_src = ca;
            scr_pkg::SRC_HIGH: pick_src = 1'b1;
            default: pick_src = 1'b0;
        endcase
    endfunction

    // register writes and reads; reserved bits stay zero
    // the status offset is read-only, so a write there is dropped
    always_comb begin
        next_ctrl = ctrl;
        next_rdata = 32'h0000_0000; // unmapped reads give zero
        if (reg_wr && reg_addr == ADDR_W'(scr_pkg::PIN_CTRL_OFS)) begin
            next_ctrl = scr_pkg::scr_ctrl_t'(reg_wdata);
            next_ctrl.rsv = 8'h00;
        end
        if (reg_rd && reg_addr == ADDR_W'(scr_pkg::PIN_CTRL_OFS)) begin
            next_rdata = ctrl;
        end else if (reg_rd &&
                     reg_addr == ADDR_W'(scr_pkg::PIN_STAT_OFS)) begin
            next_rdata = {{(32 - scr_pkg::ST_W){1'b0}}, stat};
        end
    end

    // register the control word and read data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl <= scr_pkg::PIN_CTRL_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            reg_rdata <= next_rdata;
        end
    end

    // status samples raw pin inputs only, never the internal loop
    always_comb begin
        next_stat = '0;
        next_stat[scr_pkg::ST_CLK1] = clk_pin1_i;
        next_stat[scr_pkg::ST_CLK2] = clk_pin2_i;
        next_stat[scr_pkg::ST_DAT1] = dat_pin1_i;
        next_stat[scr_pkg::ST_DAT2] = dat_pin2_i;
        next_stat[scr_pkg::ST_HS1] = hs_pin1_i;
        next_stat[scr_pkg::ST_HS2] = hs_pin2_i;
        next_stat[scr_pkg::ST_DCD] = dcd_pin_i;
        next_stat[scr_pkg::ST_AUX] = aux_pin_i;
    end

    assign tx_at2 = ctrl.dce;

    // receive clock: remote pin normally, own tx pin in external loop
    always_comb begin
        if (ctrl.ext_lb) begin
            rx_clk = tx_at2 ? clk_pin2_i : clk_pin1_i;
        end else begin
            rx_clk = tx_at2 ? clk_pin1_i : clk_pin2_i;
        end
    end

    // clock selection stays combinational so edges are not delayed
    assign tx_clk = pick_src(ctrl.txc_src, channel_pll_clock, rx_clk,
        aux_pin_i, ctl_clk_b_i, ctl_clk_a_i);

    // controller clock pins; software keeps the controller opposite
    // a pin sourced from itself while driven loops back on itself,
    // so that code is only useful with the pin left as an input
    always_comb begin
        ctl_clk_a_o = pick_src(ctrl.a_src, channel_pll_clock, rx_clk,
            aux_pin_i, ctl_clk_b_i, ctl_clk_a_i);
        ctl_clk_b_o = pick_src(ctrl.b_src, channel_pll_clock, rx_clk,
            aux_pin_i, ctl_clk_b_i, ctl_clk_a_i);
        ctl_clk_a_oe = ctrl.a_drive;
        ctl_clk_b_oe = ctrl.b_drive;
    end

    // cable clock pins: transmit clock always leaves, side per mode
    // with the transceivers off neither clock pin is driven
    always_comb begin
        clk_pin1_o = tx_clk;
        clk_pin2_o = tx_clk;
        clk_pin1_oe = ctrl.xcvr_en && !tx_at2;
        clk_pin2_oe = ctrl.xcvr_en && tx_at2;
    end

    // transmit data and rts, each overridable to a software level
    always_comb begin
        next_txd = ctrl.txd_gp[1] ? ctrl.txd_gp[0] : ctl_txd;
        next_rts = ctrl.rts_gp[1] ? ctrl.rts_gp[0] : ctl_rts;
    end

    // receive side: internal loop wins, else transceiver inputs
    always_comb begin
        if (ctrl.int_lb) begin
            next_rxd = ctl_txd;
            next_cts = ctl_rts;
        end else if (ctrl.ext_lb) begin
            next_rxd = tx_at2 ? dat_pin2_i : dat_pin1_i;
            next_cts = tx_at2 ? hs_pin2_i : hs_pin1_i;
        end else begin
            next_rxd = tx_at2 ? dat_pin1_i : dat_pin2_i;
            next_cts = tx_at2 ? hs_pin1_i : hs_pin2_i;
        end
        // an output dcd is looped to the controller at its set level
        next_dcd = ctrl.dcd[1] ? ctrl.dcd[0] : dcd_pin_i;
    end

    // data path flops: one cycle through the block each way
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxd_q <= 1'b1;
            cts_q <= 1'b0;
            dcd_q <= 1'b0;
            txd_q <= 1'b1;
            rts_q <= 1'b0;
            stat <= '0;
        end else begin
            rxd_q <= next_rxd;
            cts_q <= next_cts;
            dcd_q <= next_dcd;
            txd_q <= next_txd;
            rts_q <= next_rts;
            stat <= next_stat;
        end
    end

    assign ctl_rxd = rxd_q;
    assign ctl_cts = cts_q;
    assign ctl_dcd = dcd_q;
    assign rs232_mode = ctrl.rs232;

    // data and handshake pins; disabled transceivers drive nothing
    always_comb begin
        dat_pin1_o = txd_q;
        dat_pin2_o = txd_q;
        hs_pin1_o = rts_q;
        hs_pin2_o = rts_q;
        dat_pin1_oe = ctrl.xcvr_en && !tx_at2;
        dat_pin2_oe = ctrl.xcvr_en && tx_at2;
        hs_pin1_oe = ctrl.xcvr_en && !tx_at2;
        hs_pin2_oe = ctrl.xcvr_en && tx_at2;
        dcd_pin_o = ctrl.dcd[0];
        dcd_pin_oe = ctrl.xcvr_en && ctrl.dcd[1];
        aux_pin_o = ctrl.aux[0];
        aux_pin_oe = ctrl.xcvr_en && ctrl.aux[1];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // a write reaches the control word one edge later
    sequence s_ctrl_wr;
        reg_wr && reg_addr == ADDR_W'(scr_pkg::PIN_CTRL_OFS);
    endsequence
    sequence s_ctrl_rd;
        reg_rd && reg_addr == ADDR_W'(scr_pkg::PIN_CTRL_OFS);
    endsequence

    wr_then_read_a: assert property (s_ctrl_wr ##1 s_ctrl_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & 32'h807F_FFFF))
        else $error("control read does not return last write");
    tx_clock_out_a: assert property (ctrl.xcvr_en |->
        (clk_pin1_oe ^ clk_pin2_oe))
        else $error("transmit clock not driven on exactly one pin");
    dce_swap_a: assert property (ctrl.xcvr_en && ctrl.dce |->
        dat_pin2_oe && !dat_pin1_oe && hs_pin2_oe && !hs_pin1_oe)
        else $error("dce mode pin directions wrong");
    xcvr_off_a: assert property (!ctrl.xcvr_en |->
        !(clk_pin1_oe || dat_pin1_oe || dat_pin2_oe || dcd_pin_oe))
        else $error("cable driven with transceivers off");
    int_loop_a: assert property (ctrl.int_lb ##1 ctrl.int_lb |->
        ctl_rxd == $past(ctl_txd) && ctl_cts == $past(ctl_rts))
        else $error("internal loopback data mismatch");
    status_pin_a: assert property (reg_rd &&
        reg_addr == ADDR_W'(scr_pkg::PIN_STAT_OFS) |-> ##1
        reg_rdata[scr_pkg::ST_DAT1] == $past(dat_pin1_i, 2))
        else $error("status does not show pin level");
    txc_pll_a: assert property (ctrl.txc_src == scr_pkg::SRC_PLL
        |-> clk_pin1_o == channel_pll_clock)
        else $error("transmit clock not from pll");
    ctl_drive_a: assert property (s_ctrl_wr |=>
        ctl_clk_b_oe == $past(reg_wdata[10]))
        else $error("controller pin b direction not updated");
    aux_dir_a: assert property (ctrl.xcvr_en |->
        aux_pin_oe == ctrl.aux[1] && dcd_pin_oe == ctrl.dcd[1])
        else $error("aux or dcd direction wrong");
    reset_route_a: assert property ($rose(rst_n) |->
        ctrl.a_src == scr_pkg::SRC_RXC && ctrl.b_src == scr_pkg::SRC_PLL)
        else $error("reset clock routing wrong");
    proto_a: assert property (s_ctrl_wr |=>
        rs232_mode == $past(reg_wdata[11]))
        else $error("protocol select not applied");
    // external loop takes receive data back from this side's own pin
    ext_loop_a: assert property (ctrl.ext_lb && !ctrl.int_lb &&
        !ctrl.dce |=> ctl_rxd == $past(dat_pin1_i))
        else $error("external loopback does not return pin data");
    // a forced rts level reaches the pin one edge later
    gp_force_a: assert property (ctrl.rts_gp[1] |=>
        hs_pin1_o == $past(ctrl.rts_gp[0]))
        else $error("forced rts level not on the pin");
    // an output dcd is seen by the controller at its set level
    dcd_level_a: assert property (ctrl.dcd[1] |=>
        ctl_dcd == $past(ctrl.dcd[0]))
        else $error("output dcd level not fed to the controller");

endmodule

// >>> dv/scr_cable_model.sv
// remote serial equipment model: resolves each cable wire between both ends
`timescale 1ns/100ps
module scr_cable_model (
    input wire logic clk_sys, // system clock
    input wire logic [7:0] blk_o, // block levels, status bit order
    input wire logic [7:0] blk_oe, // block drive enables
    input wire logic [7:0] far_o, // levels the remote end sends
    input wire logic [7:0] far_oe, // pins the remote end drives
    output logic [7:0] lvl, // resolved wire levels
    output logic clash // both ends drive one pin
);
    logic [7:0] idle_pat = 8'h5A; // floating wires, flipped every cycle
    // no pull on these pairs, so a released wire must not keep a stale level
    always_ff @(posedge clk_sys) begin
        idle_pat <= ~idle_pat;
    end
    // remote drives only the pins that its own role owns
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = blk_oe[i] ? blk_o[i] :
                (far_oe[i] ? far_o[i] : idle_pat[i]);
        end
    end
    // a wire driven from both ends means a direction fault
    assign clash = |(blk_oe & far_oe);
endmodule

// >>> dv/tb.sv
// self-checking bench for the cable clock and pin routing block
`timescale 1ns/100ps
module tb;
    logic clk_sys, rst_n; // clock and synchronous reset
    logic [3:0] reg_addr; // register address
    logic [31:0] reg_wdata, reg_rdata, st; // write, read, last read
    logic reg_wr, reg_rd; // register strobes
    logic channel_pll_clock, ctl_txd, ctl_rts; // controller side inputs
    logic ctl_a_drv, ctl_b_drv; // controller drive on its clock pins
    logic ctl_clk_a_i, ctl_clk_a_o, ctl_clk_a_oe; // controller pin a
    logic ctl_clk_b_i, ctl_clk_b_o, ctl_clk_b_oe; // controller pin b
    logic ctl_rxd, ctl_cts, ctl_dcd, rs232_mode; // toward the controller
    logic clk_pin1_i, clk_pin1_o, clk_pin1_oe; // cable clock, dte tx side
    logic clk_pin2_i, clk_pin2_o, clk_pin2_oe; // cable clock, dte rx side
    logic dat_pin1_i, dat_pin1_o, dat_pin1_oe; // cable data, dte tx side
    logic dat_pin2_i, dat_pin2_o, dat_pin2_oe; // cable data, dte rx side
    logic hs_pin1_i, hs_pin1_o, hs_pin1_oe; // handshake, dte rts side
    logic hs_pin2_i, hs_pin2_o, hs_pin2_oe; // handshake, dte cts side
    logic dcd_pin_i, dcd_pin_o, dcd_pin_oe; // carrier detect pin
    logic aux_pin_i, aux_pin_o, aux_pin_oe; // auxiliary clock pin
    logic [7:0] far_o, far_oe, lvl, blk_o, blk_oe, t; // wires, expectations
    logic clash; // contention flag from the model
    logic [4:0] pat [3] = '{5'h15, 5'h06, 5'h18}; // {a,b,aux,rxc,pll}
    int miscompares, check_count; // error and check counters
    scr_pkg::scr_ctrl_t cw, base; // control words
    assign blk_o = {aux_pin_o, dcd_pin_o, hs_pin2_o, hs_pin1_o, dat_pin2_o,
        dat_pin1_o, clk_pin2_o, clk_pin1_o};
    assign blk_oe = {aux_pin_oe, dcd_pin_oe, hs_pin2_oe, hs_pin1_oe,
        dat_pin2_oe, dat_pin1_oe, clk_pin2_oe, clk_pin1_oe};
    assign {aux_pin_i, dcd_pin_i, hs_pin2_i, hs_pin1_i, dat_pin2_i,
        dat_pin1_i, clk_pin2_i, clk_pin1_i} = lvl;
    // controller drives its clock pins only while the block lets go
    assign ctl_clk_a_i = ctl_clk_a_oe ? ctl_clk_a_o : ctl_a_drv;
    assign ctl_clk_b_i = ctl_clk_b_oe ? ctl_clk_b_o : ctl_b_drv;
    scr_pin_route i_scr_pin_route (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .channel_pll_clock, .ctl_clk_a_i, .ctl_clk_a_o, .ctl_clk_a_oe,
        .ctl_clk_b_i, .ctl_clk_b_o, .ctl_clk_b_oe, .ctl_txd, .ctl_rts,
        .ctl_rxd, .ctl_cts, .ctl_dcd, .rs232_mode, .clk_pin1_i, .clk_pin1_o,
        .clk_pin1_oe, .clk_pin2_i, .clk_pin2_o, .clk_pin2_oe, .dat_pin1_i,
        .dat_pin1_o, .dat_pin1_oe, .dat_pin2_i, .dat_pin2_o, .dat_pin2_oe,
        .hs_pin1_i, .hs_pin1_o, .hs_pin1_oe, .hs_pin2_i, .hs_pin2_o,
        .hs_pin2_oe, .dcd_pin_i, .dcd_pin_o, .dcd_pin_oe, .aux_pin_i,
        .aux_pin_o, .aux_pin_oe);
    scr_cable_model i_scr_cable_model (
        .clk_sys, .blk_o, .blk_oe, .far_o, .far_oe, .lvl, .clash);
    // 20 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // compare words, counting every check
    task automatic check_word(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // compare single levels
    task automatic check_bit(input string n, input logic e, g);
        check_word(n, {31'h0, e}, {31'h0, g});
    endtask
    // one-cycle write strobe
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe; data only stands in the following cycle
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        st = reg_rdata;
    endtask
    // write then read back to back, the slave never stalls
    task automatic wr_rd(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        st = reg_rdata;
    endtask
    task automatic read_chk(input string n, input logic [3:0] a,
        input logic [31:0] e);
        reg_read(a);
        check_word(n, e, st);
    endtask
    // let n edges pass, then look at settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        channel_pll_clock = 1'b1; // pll feeds pin b as controller input
        {ctl_txd, ctl_rts, ctl_a_drv, ctl_b_drv} = 4'h8;
        far_o = 8'h00;
        far_oe = 8'h02; // remote sends a low receive clock
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(0);
        check_bit("pin_a_oe", 1'b1, ctl_clk_a_oe);
        check_bit("pin_b_oe", 1'b1, ctl_clk_b_oe);
        check_bit("pin_b_clk", 1'b1, ctl_clk_b_o);
        check_bit("pin_a_clk", 1'b0, ctl_clk_a_o);
        check_word("reset_oe", 32'h0, {24'h0, blk_oe});
        read_chk("reset_ctrl", scr_pkg::PIN_CTRL_OFS, 32'h00000602);
        // every bit set, cable unplugged; reserved and status writes vanish
        @(posedge clk_sys);
        far_oe <= 8'h00;
        reg_write(scr_pkg::PIN_CTRL_OFS, 32'hFFFFFFFF);
        reg_write(scr_pkg::PIN_STAT_OFS, 32'h0);
        read_chk("ctrl_all", scr_pkg::PIN_CTRL_OFS, 32'h807FFFFF);
        read_chk("unmapped", 4'h8, 32'h0);
        check_word("dce_oe", 32'hEA, {24'h0, blk_oe});
        check_bit("txc_low", 1'b0, clk_pin2_o);
        check_bit("aux_lvl", 1'b1, aux_pin_o);
        check_bit("dcd_lvl", 1'b1, dcd_pin_o);
        check_bit("rts_force", 1'b1, hs_pin2_o);
        check_bit("dcd_ctl", 1'b1, ctl_dcd);
        check_bit("rs232", 1'b1, rs232_mode);
        // every source code, three level patterns that tell sources apart
        base = '0;
        base.xcvr_en = 1'b1;
        base.txc_src = scr_pkg::SRC_HIGH;
        @(posedge clk_sys);
        far_oe <= 8'hEA;
        for (int p = 0; p < 3; p++) begin
            @(posedge clk_sys);
            {ctl_a_drv, ctl_b_drv, far_o[7], far_o[1], channel_pll_clock}
                <= pat[p];
            t = {1'b0, 1'b1, pat[p][4:1], ~pat[p][0], pat[p][0]};
            for (int k = 0; k < 8; k++) begin
                cw = base;
                cw.txc_src = scr_pkg::scr_src_t'(k[2:0]);
                cw.a_src = cw.txc_src;
                cw.b_src = cw.txc_src;
                wr_rd(scr_pkg::PIN_CTRL_OFS, cw);
                check_word("src_ctrl", cw, st);
                check_bit("txc_pin", t[k], clk_pin1_o);
                check_bit("pin_a_src", t[k], ctl_clk_a_o);
                check_bit("pin_b_src", t[k], ctl_clk_b_o);
            end
        end
        check_word("dte_oe", 32'h15, {24'h0, blk_oe});
        check_bit("pin_a_off", 1'b0, ctl_clk_a_oe);
        check_bit("rs422", 1'b0, rs232_mode);
        // data and handshake both ways, dte then dce, with status readback
        for (int d = 0; d < 2; d++) begin
            cw = base;
            cw.dce = d[0];
            @(posedge clk_sys);
            far_oe <= d[0] ? 8'hD5 : 8'hEA;
            reg_write(scr_pkg::PIN_CTRL_OFS, cw);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk_sys);
                ctl_txd <= v[0];
                ctl_rts <= ~v[0];
                far_o <= {v[0], ~v[0], v[0], v[0], ~v[0], ~v[0], 2'b00};
                tick(3);
                check_bit("tx_data", v[0],
                    d[0] ? dat_pin2_o : dat_pin1_o);
                check_bit("tx_rts", ~v[0],
                    d[0] ? hs_pin2_o : hs_pin1_o);
                check_bit("rx_data", ~v[0], ctl_rxd);
                check_bit("rx_cts", v[0], ctl_cts);
                check_bit("dcd_in", ~v[0], ctl_dcd);
                check_bit("no_clash", 1'b0, clash);
                read_chk("status", scr_pkg::PIN_STAT_OFS, {24'h0, v[0], ~v[0],
                    {v[0], ~v[0], ~v[0], v[0], 2'h1} ^ {6{d[0]}}});
            end
        end
        // external loop with nothing plugged in, then internal loop
        for (int m = 0; m < 2; m++) begin
            cw = base;
            cw.ext_lb = ~m[0];
            cw.int_lb = m[0];
            @(posedge clk_sys);
            far_oe <= m[0] ? 8'hEA : 8'h00;
            reg_write(scr_pkg::PIN_CTRL_OFS, cw);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk_sys);
                ctl_txd <= v[0];
                ctl_rts <= ~v[0];
                far_o <= {8{~v[0]}};
                tick(3);
                check_bit("lb_rxd", v[0], ctl_rxd);
                check_bit("lb_cts", ~v[0], ctl_cts);
                check_bit("lb_pin", v[0], dat_pin1_o);
                reg_read(scr_pkg::PIN_STAT_OFS);
                if (m == 1) begin
                    check_bit("lb_stat", ~v[0], st[3]);
                end
            end
        end
        // drivers off: nothing reaches the cable, only pin a is driven
        cw = base;
        cw.xcvr_en = 1'b0;
        cw.int_lb = 1'b1;
        cw.dcd = 2'h3;
        cw.aux = 2'h3;
        cw.a_drive = 1'b1;
        reg_write(scr_pkg::PIN_CTRL_OFS, cw);
        tick(0);
        check_word("off_oe", 32'h0, {24'h0, blk_oe});
        check_bit("pin_a_on", 1'b1, ctl_clk_a_oe);
        check_bit("pin_b_in", 1'b0, ctl_clk_b_oe);
        print_verdict();
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
endmodule
